// ---- logic/stim3_cfg.sv ----
`timescale 1ns/10ps
module stim3_cfg (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire stim3_cfg_pkg::reg_wr_s i_wr,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic [2:0] i_stim3_usage_sel,
  input wire stim3_cfg_pkg::profile_e i_profile,
  output stim3_cfg_pkg::stim3_apply_s o_apply
);
  import stim3_cfg_pkg::*;

  logic [1:0] stim3_pull_current_sel_q;
  logic [3:0] stim3_threshold_sel_q;
  logic [7:0] pull_ua;
  logic [11:0] thr_mv;
  stim3_apply_s apply_d;
  stim3_apply_s apply_q;

  // write decode
  wire hit = i_wr.wr && (i_wr.addr == STIM3_CFG3_ADDR);
  wire legacy_run = (i_profile == PROF_LEGACY);
  wire [1:0] wr_pull = i_wr.wdata[PULL_LSB +: 2];
  wire [3:0] wr_thr = i_wr.wdata[THR_LSB +: 4];
  wire thr_ok = (wr_thr != THR_RESERVED);
  wire wr_en = hit && !legacy_run;
  wire bc12 = (i_profile == PROF_BC12);
  wire thr_used = (i_stim3_usage_sel != USAGE_VBUS_READY) &&
                  (i_stim3_usage_sel != USAGE_VBUS_PRESENT);

  // field storage
  // reset zero
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      stim3_pull_current_sel_q <= PULL_RESET;
      stim3_threshold_sel_q <= THR_RESET;
    end else if (wr_en) begin
      stim3_pull_current_sel_q <= wr_pull;
      if (thr_ok) begin
        stim3_threshold_sel_q <= wr_thr;
      end
    end
  end

  stim3_decode u_dec (
    .i_pull_sel(stim3_pull_current_sel_q),
    .i_thr_sel(stim3_threshold_sel_q),
    .o_pull_ua(pull_ua),
    .o_thr_mv(thr_mv)
  );

  // applied settings, zero when not bc12
  always_comb begin
    apply_d.active = bc12;
    apply_d.pull_ua = bc12 ? pull_ua : 8'h00;
    apply_d.thr_used = bc12 && thr_used;
    apply_d.thr_mv = (bc12 && thr_used) ? thr_mv : 12'h000;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      apply_q <= '0;
    end else begin
      apply_q <= apply_d;
    end
  end
  assign o_apply = apply_q;

  // readback, upper bits zero
  // unimplemented zero
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_addr == STIM3_CFG3_ADDR) begin
      o_rd_data <= {2'h0, stim3_pull_current_sel_q, stim3_threshold_sel_q};
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // reserved threshold never lands
  reserved_reject_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    hit && !thr_ok |=> stim3_threshold_sel_q == $past(stim3_threshold_sel_q))
    else $error("reserved threshold accepted");
  legacy_freeze_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    legacy_run |=> $stable(stim3_pull_current_sel_q) && $stable(stim3_threshold_sel_q))
    else $error("field changed under legacy");
  write_lands_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    hit && !legacy_run |=> stim3_pull_current_sel_q == $past(wr_pull))
    else $error("write not stored");
  bc12_only_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !bc12 |=> !o_apply.active && o_apply.pull_ua == 8'h00)
    else $error("applied outside bc12");
  thr_ignore_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_stim3_usage_sel == 3'h0 || i_stim3_usage_sel == 3'h7) |=> !o_apply.thr_used)
    else $error("threshold used for vbus usage");
  thr_1600_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'hB |=> o_apply.thr_mv == 12'h640)
    else $error("threshold decode wrong");
  read_upper_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_rd_data[7:6] == 2'h0)
    else $error("upper bits nonzero");
  usage_default_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_stim3_usage_sel == 3'h0 |=> o_apply.thr_mv == 12'h000)
    else $error("usage 000 applied a threshold");

  // fields come out of reset at zero
  fields_reset_a: assert property (@(posedge i_core_clk)
    i_srst |=> stim3_pull_current_sel_q == PULL_RESET && stim3_threshold_sel_q == THR_RESET)
    else $error("fields not cleared by reset");

  // applied settings cleared by reset
  apply_reset_a: assert property (@(posedge i_core_clk)
    i_srst |=> o_apply == '0)
    else $error("applied settings not cleared by reset");

  // read data cleared by reset
  read_reset_a: assert property (@(posedge i_core_clk)
    i_srst |=> o_rd_data == 8'h00)
    else $error("read data not cleared by reset");

  // accepted threshold code lands as written
  thr_lands_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    hit && !legacy_run && thr_ok |=> stim3_threshold_sel_q == $past(wr_thr))
    else $error("threshold write not stored");

  // reserved threshold code is never held
  thr_never_rsvd_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    stim3_threshold_sel_q != THR_RESERVED)
    else $error("reserved threshold held");

  // no accepted write, no field change
  hold_no_write_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !wr_en |=> $stable(stim3_pull_current_sel_q) && $stable(stim3_threshold_sel_q))
    else $error("field changed without write");

  // readback mirrors both fields
  read_mirror_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_rd_addr == STIM3_CFG3_ADDR |=>
      o_rd_data == {2'h0, $past(stim3_pull_current_sel_q), $past(stim3_threshold_sel_q)})
    else $error("read data differs from fields");

  // other addresses read zero
  read_other_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_rd_addr != STIM3_CFG3_ADDR |=> o_rd_data == 8'h00)
    else $error("other address read nonzero");

  // settings active under bc12
  active_bc12_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 |=> o_apply.active)
    else $error("bc12 settings not applied");

  // legacy profile applies nothing
  legacy_zero_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    legacy_run |=> o_apply == '0)
    else $error("settings applied under legacy");

  // no threshold outside bc12
  thr_none_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !bc12 |=> !o_apply.thr_used && o_apply.thr_mv == 12'h000)
    else $error("threshold applied outside bc12");

  // comparator usages do use the threshold
  thr_used_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && (i_stim3_usage_sel == 3'h1 || i_stim3_usage_sel == 3'h2 ||
      i_stim3_usage_sel == 3'h3 || i_stim3_usage_sel == 3'h6) |=> o_apply.thr_used)
    else $error("threshold not used by comparator");

  // pull code 00 gives 10 uA
  pull_10_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && stim3_pull_current_sel_q == 2'h0 |=> o_apply.pull_ua == 8'h0A)
    else $error("pull decode wrong for 00");

  // pull code 01 gives 50 uA
  pull_50_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && stim3_pull_current_sel_q == 2'h1 |=> o_apply.pull_ua == 8'h32)
    else $error("pull decode wrong for 01");

  // pull code 10 gives 100 uA
  pull_100_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && stim3_pull_current_sel_q == 2'h2 |=> o_apply.pull_ua == 8'h64)
    else $error("pull decode wrong for 10");

  // pull code 11 gives 150 uA
  pull_150_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && stim3_pull_current_sel_q == 2'h3 |=> o_apply.pull_ua == 8'h96)
    else $error("pull decode wrong for 11");

  // threshold code 0000 gives 400 mV
  thr_400_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'h0 |=> o_apply.thr_mv == 12'h190)
    else $error("threshold decode wrong for 0000");

  // threshold code 0011 gives 300 mV
  thr_300_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'h3 |=> o_apply.thr_mv == 12'h12C)
    else $error("threshold decode wrong for 0011");

  // threshold code 0101 gives 500 mV
  thr_500_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'h5 |=> o_apply.thr_mv == 12'h1F4)
    else $error("threshold decode wrong for 0101");

  // threshold code 1001 gives 900 mV
  thr_900_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'h9 |=> o_apply.thr_mv == 12'h384)
    else $error("threshold decode wrong for 1001");

  // threshold code 1010 gives 1400 mV
  thr_1400_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'hA |=> o_apply.thr_mv == 12'h578)
    else $error("threshold decode wrong for 1010");

  // threshold code 1100 gives 1800 mV
  thr_1800_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'hC |=> o_apply.thr_mv == 12'h708)
    else $error("threshold decode wrong for 1100");

  // threshold code 1101 gives 2000 mV
  thr_2000_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'hD |=> o_apply.thr_mv == 12'h7D0)
    else $error("threshold decode wrong for 1101");

  // threshold code 1110 gives 2200 mV
  thr_2200_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    bc12 && thr_used && stim3_threshold_sel_q == 4'hE |=> o_apply.thr_mv == 12'h898)
    else $error("threshold decode wrong for 1110");
endmodule

// ---- include/stim3_cfg_pkg.sv ----
package stim3_cfg_pkg;
  localparam logic [7:0] STIM3_CFG3_ADDR = 8'h4B;
  localparam int PULL_LSB = 4;
  localparam int THR_LSB = 0;
  localparam logic [1:0] PULL_RESET = 2'h0;
  localparam logic [3:0] THR_RESET = 4'h0;
  localparam logic [3:0] THR_RESERVED = 4'hF;
  localparam logic [2:0] USAGE_VBUS_READY = 3'h0;
  localparam logic [2:0] USAGE_VBUS_PRESENT = 3'h7;

  typedef enum logic [1:0] {
    PROF_NONE = 2'b00,
    PROF_BC12 = 2'b01,
    PROF_LEGACY = 2'b10
  } profile_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } reg_wr_s;

  typedef struct packed {
    logic active;
    logic [7:0] pull_ua;
    logic thr_used;
    logic [11:0] thr_mv;
  } stim3_apply_s;
endpackage

// ---- logic/stim3_decode.sv ----
`timescale 1ns/10ps
module stim3_decode (
  input wire logic [1:0] i_pull_sel,
  input wire logic [3:0] i_thr_sel,
  output logic [7:0] o_pull_ua,
  output logic [11:0] o_thr_mv
);
  import stim3_cfg_pkg::*;

  // pull-up current in microamps
  // current decode
  function automatic logic [7:0] pull_ua(input logic [1:0] c);
    case (c)
      2'h0: pull_ua = 8'h0A;
      2'h1: pull_ua = 8'h32;
      2'h2: pull_ua = 8'h64;
      default: pull_ua = 8'h96;
    endcase
  endfunction

  // threshold in millivolts, reserved code gives zero
  // threshold decode
  function automatic logic [11:0] thr_mv(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h4: thr_mv = 12'h190;
      4'h3: thr_mv = 12'h12C;
      4'h5: thr_mv = 12'h1F4;
      4'h6: thr_mv = 12'h258;
      4'h7: thr_mv = 12'h2BC;
      4'h8: thr_mv = 12'h320;
      4'h9: thr_mv = 12'h384;
      4'hA: thr_mv = 12'h578;
      4'hB: thr_mv = 12'h640;
      4'hC: thr_mv = 12'h708;
      4'hD: thr_mv = 12'h7D0;
      4'hE: thr_mv = 12'h898;
      default: thr_mv = 12'h000;
    endcase
  endfunction

  assign o_pull_ua = pull_ua(i_pull_sel);
  assign o_thr_mv = thr_mv(i_thr_sel);
endmodule

// ---- testbench/stim3_host.sv ----
`timescale 1ns/10ps
// host model: byte writes and reads of the register
module stim3_host (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rd_data,
  output stim3_cfg_pkg::reg_wr_s o_wr,
  output logic [7:0] o_rd_addr
);
  import stim3_cfg_pkg::*;
  // idle bus at time zero
  initial begin
    o_wr = '0;
    o_rd_addr = STIM3_CFG3_ADDR;
  end
  // one-cycle strobe, then let registered outputs settle
  task automatic wr(input logic [7:0] d);
    @(negedge i_core_clk);
    o_wr = '{addr: STIM3_CFG3_ADDR, wdata: d, wr: 1'b1};
    @(negedge i_core_clk);
    o_wr.wr = 1'b0;
    repeat (2) @(negedge i_core_clk);
  endtask
  // read data is registered one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_rd_addr = a;
    repeat (2) @(negedge i_core_clk);
    d = i_rd_data;
  endtask
endmodule

// ---- testbench/stim3_cfg_test.sv ----
`timescale 1ns/10ps
module stim3_cfg_test;
  import stim3_cfg_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  reg_wr_s wr;
  logic [7:0] ra, rdat, v;
  logic [2:0] use_sel = 3'h1;
  profile_e prof = PROF_BC12;
  stim3_apply_s ap;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] pu [4] = '{8'h0A, 8'h32, 8'h64, 8'h96};
  stim3_cfg i_stim3_cfg (.i_core_clk(clk), .i_srst(srst), .i_wr(wr), .i_rd_addr(ra),
    .o_rd_data(rdat), .i_stim3_usage_sel(use_sel), .i_profile(prof), .o_apply(ap));
  stim3_host i_stim3_host (.i_core_clk(clk), .i_rd_data(rdat), .o_wr(wr), .o_rd_addr(ra));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog well beyond the roughly 60 cycles of the tests
  initial begin
    #100000;
    err_count++;
    test_done();
  end
  // test sequence
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(ap), 32'h0);
    chk(32'(rdat), 32'h0);
    srst = 1'b0;
    i_stim3_host.rd(8'h4B, v);
    chk(32'(v), 32'h0);
    chk(32'({ap.active, ap.thr_used, ap.pull_ua}), 32'h30A);
    chk(32'(ap.thr_mv), 32'h190);
    i_stim3_host.wr(8'hFB);
    i_stim3_host.rd(8'h4B, v);
    chk(32'(v), 32'h3B);
    chk(32'(ap.thr_mv), 32'h640);
    for (int i = 0; i < 4; i++) begin
      i_stim3_host.wr({2'h0, i[1:0], 4'hC});
      chk(32'(ap.pull_ua), 32'(pu[i]));
    end
    chk(32'(ap.thr_mv), 32'h708);
    i_stim3_host.wr(8'h1F);
    i_stim3_host.rd(8'h4B, v);
    chk(32'(v), 32'h1C);
    use_sel = USAGE_VBUS_READY;
    repeat (2) @(negedge clk);
    chk(32'({ap.active, ap.thr_used}), 32'h2);
    chk(32'(ap.thr_mv), 32'h0);
    use_sel = USAGE_VBUS_PRESENT;
    repeat (2) @(negedge clk);
    chk(32'({ap.active, ap.thr_used}), 32'h2);
    chk(32'(ap.thr_mv), 32'h0);
    i_stim3_host.rd(8'h4A, v);
    chk(32'(v), 32'h0);
    prof = PROF_LEGACY;
    i_stim3_host.wr(8'h00);
    i_stim3_host.rd(8'h4B, v);
    chk(32'(v), 32'h1C);
    chk(32'(ap), 32'h0);
    // no profile: writes land, nothing applied
    prof = PROF_NONE;
    i_stim3_host.wr(8'h25);
    i_stim3_host.rd(8'h4B, v);
    chk(32'(v), 32'h25);
    chk(32'(ap), 32'h0);
    // second reset in mid-run clears fields and outputs
    prof = PROF_BC12;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(ap), 32'h0);
    chk(32'(rdat), 32'h0);
    srst = 1'b0;
    i_stim3_host.rd(8'h4B, v);
    chk(32'(v), 32'h0);
    test_done();
  end
endmodule
